// *** design/mrc_cal_policy.v ***
// mrc_cal_policy.v: decides when the synthesizer is calibrated automatically.
// assumes: transition pulses are one cycle wide and come from the radio fsm.
`timescale 1ns/1ps
`default_nettype none
`include "mrc_defs.vh"
module mrc_cal_policy (
  input wire clock_i,
  input wire resetn_i,
  input wire [1:0] synth_autocalibration_policy_i,
  input wire idle_to_rx_i,
  input wire auto_rx_to_idle_i,
  output wire cal_request_o
);
  reg [1:0] return_count_r;
  reg [1:0] return_count_nxt;

  // counter only advances in every-4th mode so switching modes starts fresh
  always @*
  begin
    return_count_nxt = return_count_r;
    if (synth_autocalibration_policy_i != `MRC_CAL_EVERY_4TH)
      return_count_nxt = 2'h0;
    else if (auto_rx_to_idle_i)
      return_count_nxt = return_count_r + 2'h1;
  end

  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      return_count_r <= 2'h0;
    else
      return_count_r <= return_count_nxt;
  end

  // never mode asserts nothing, host must use the calibration strobe
  assign cal_request_o =
    ((synth_autocalibration_policy_i == `MRC_CAL_IDLE_TO_RX) && idle_to_rx_i) ||
    ((synth_autocalibration_policy_i == `MRC_CAL_RX_TO_IDLE) && auto_rx_to_idle_i) ||
    ((synth_autocalibration_policy_i == `MRC_CAL_EVERY_4TH) && auto_rx_to_idle_i &&
     (return_count_r == 2'h3));
endmodule // mrc_cal_policy
`default_nettype wire

// *** design/mrc_cfg_bank.v ***
// mrc_cfg_bank.v: modem and radio control configuration registers with the
// small decisions that read them.
// assumes: register port is a synchronous byte write/read at 6-bit address,
// fed by the serial interface; radio events are one-cycle pulses.
//
// Functional notes
// - two-bit channel spacing exponent in low bits of first modem register, reset 10.
// - eight-bit spacing mantissa reset 0xf8 sets channel spacing with exponent.
// - deviation exponent bits 6:4 reset 4, mantissa bits 2:0 reset 7.
// - with on-off keying the deviation mantissa has no effect.
// - received_signal_strength termination bit ends rx when carrier sense drops; ook times out after 8 symbols.
// - receive-off field picks next state after packet: 00 idle, 11 stay rx.
// - autocalibration 00 never calibrates; host must issue calibration strobe.
// - 01 calibrate idle to rx, 10 on auto return, 11 every fourth return.
// - vendor-tuned fields kept as read-write storage with their reset values, except the calibration register's low bits, which read 0.
`timescale 1ns/1ps
`default_nettype none
`include "mrc_defs.vh"
module mrc_cfg_bank (
  input wire clock_i,
  input wire resetn_i,
  input wire [5:0] reg_addr_i,
  input wire reg_write_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire on_off_keying_i,
  input wire symbol_tick_i,
  input wire carrier_sense_i,
  input wire rx_start_i,
  input wire packet_done_i,
  input wire idle_to_rx_i,
  input wire auto_rx_to_idle_i,
  output reg [1:0] channel_spacing_exponent_o,
  output reg [7:0] channel_spacing_mantissa_o,
  output reg [2:0] deviation_exponent_o,
  output wire [2:0] deviation_mantissa_o,
  output wire rx_terminate_o,
  output wire stay_in_rx_o,
  output wire go_idle_o,
  output wire cal_request_o
);
  reg spc_tune_r;
  reg [2:0] dev_mant_r;
  reg received_signal_strength_rx_termination_r;
  reg [3:0] term_tune_r;
  reg [1:0] exit_tune_hi_r;
  reg [1:0] receive_off_next_state_r;
  reg [1:0] exit_tune_lo_r;
  reg [1:0] synth_autocalibration_policy_r;
  reg [3:0] symbol_count_r;
  reg carrier_seen_r;
  reg [7:0] rdata_nxt;
  wire wr_spc_exp;
  wire wr_spc_mant;
  wire wr_deviation;
  wire wr_rx_term;
  wire wr_rx_exit;
  wire wr_cal;

  function hit;
    input [5:0] addr;
    input [5:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // reserved codes 01/10 fall back to idle, the safer exit
  function rxoff_stays;
    input [1:0] code;
    begin
      case (code)
        `MRC_RXOFF_STAY: rxoff_stays = 1'b1;
        `MRC_RXOFF_IDLE: rxoff_stays = 1'b0;
        default: rxoff_stays = 1'b0;
      endcase
    end
  endfunction

  // only defined bit positions are stored; the rest are dropped
  assign wr_spc_exp = reg_write_i && hit(reg_addr_i, `MRC_ADDR_SPC_EXP);
  assign wr_spc_mant = reg_write_i && hit(reg_addr_i, `MRC_ADDR_SPC_MANT);
  assign wr_deviation = reg_write_i && hit(reg_addr_i, `MRC_ADDR_DEVIATION);
  assign wr_rx_term = reg_write_i && hit(reg_addr_i, `MRC_ADDR_RX_TERM);
  assign wr_rx_exit = reg_write_i && hit(reg_addr_i, `MRC_ADDR_RX_EXIT);
  assign wr_cal = reg_write_i && hit(reg_addr_i, `MRC_ADDR_CAL);

  // one process per register keeps each field's reset beside its write
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      spc_tune_r <= `MRC_RST_SPC_TUNE;
      channel_spacing_exponent_o <= `MRC_RST_SPC_EXP;
    end
    else if (wr_spc_exp)
    begin
      spc_tune_r <= reg_wdata_i[7];
      channel_spacing_exponent_o <= reg_wdata_i[1:0];
    end
  end

  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      channel_spacing_mantissa_o <= `MRC_RST_SPC_MANT;
    else if (wr_spc_mant)
      channel_spacing_mantissa_o <= reg_wdata_i;
  end

  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      deviation_exponent_o <= `MRC_RST_DEV_EXP;
      dev_mant_r <= `MRC_RST_DEV_MANT;
    end
    else if (wr_deviation)
    begin
      deviation_exponent_o <= reg_wdata_i[6:4];
      dev_mant_r <= reg_wdata_i[2:0];
    end
  end

  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      received_signal_strength_rx_termination_r <= `MRC_RST_RECEIVED_SIGNAL_STRENGTH_TERM;
      term_tune_r <= `MRC_RST_TERM_TUNE;
    end
    else if (wr_rx_term)
    begin
      received_signal_strength_rx_termination_r <= reg_wdata_i[4];
      term_tune_r <= reg_wdata_i[3:0];
    end
  end

  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      exit_tune_hi_r <= `MRC_RST_EXIT_TUNE_HI;
      receive_off_next_state_r <= `MRC_RST_RXOFF;
      exit_tune_lo_r <= `MRC_RST_EXIT_TUNE_LO;
    end
    else if (wr_rx_exit)
    begin
      exit_tune_hi_r <= reg_wdata_i[5:4];
      receive_off_next_state_r <= reg_wdata_i[3:2];
      exit_tune_lo_r <= reg_wdata_i[1:0];
    end
  end

  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      synth_autocalibration_policy_r <= `MRC_RST_AUTOCAL;
    else if (wr_cal)
      synth_autocalibration_policy_r <= reg_wdata_i[5:4];
  end

  // unused bits are constant zero on read
  always @*
  begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      `MRC_ADDR_SPC_EXP: rdata_nxt = {spc_tune_r, 5'h00, channel_spacing_exponent_o};
      `MRC_ADDR_SPC_MANT: rdata_nxt = channel_spacing_mantissa_o;
      `MRC_ADDR_DEVIATION: rdata_nxt = {1'b0, deviation_exponent_o, 1'b0, dev_mant_r};
      `MRC_ADDR_RX_TERM: rdata_nxt = {3'h0, received_signal_strength_rx_termination_r, term_tune_r};
      `MRC_ADDR_RX_EXIT: rdata_nxt = {2'h0, exit_tune_hi_r, receive_off_next_state_r, exit_tune_lo_r};
      `MRC_ADDR_CAL: rdata_nxt = {2'h0, synth_autocalibration_policy_r, 4'h0};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= rdata_nxt;
  end

  // ook hides the mantissa so the demodulator never sees it
  assign deviation_mantissa_o = on_off_keying_i ? 3'h0 : dev_mant_r;

  // carrier-sense watch over the first 8 symbols of an rx window
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      symbol_count_r <= 4'h0;
      carrier_seen_r <= 1'b0;
    end
    else if (rx_start_i)
    begin
      symbol_count_r <= 4'h0;
      // a carrier already present as the window opens counts for it: set wins
      carrier_seen_r <= carrier_sense_i;
    end
    else
    begin
      if (carrier_sense_i)
        carrier_seen_r <= 1'b1;
      if (symbol_tick_i && (symbol_count_r != `MRC_OOK_SYMBOLS))
        symbol_count_r <= symbol_count_r + 4'h1;
    end
  end

  // fsk ends rx when carrier drops; ook ends rx if none seen in 8 symbols
  assign rx_terminate_o = received_signal_strength_rx_termination_r &&
    (on_off_keying_i ? ((symbol_count_r == `MRC_OOK_SYMBOLS) && !carrier_seen_r && !carrier_sense_i)
                     : !carrier_sense_i);

  // both exits share one decode so exactly one fires per packet
  assign stay_in_rx_o = packet_done_i && rxoff_stays(receive_off_next_state_r);
  assign go_idle_o = packet_done_i && !rxoff_stays(receive_off_next_state_r);

  mrc_cal_policy u_cal (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .synth_autocalibration_policy_i(synth_autocalibration_policy_r),
    .idle_to_rx_i(idle_to_rx_i),
    .auto_rx_to_idle_i(auto_rx_to_idle_i),
    .cal_request_o(cal_request_o)
  );
endmodule // mrc_cfg_bank
`default_nettype wire

// *** dv/mrc_cfg_bank_properties.sv ***
// checker of the modem and radio control bank
// assumes: bound to mrc_cfg_bank, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module mrc_cfg_bank_properties (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic on_off_keying_i,
  input wire logic packet_done_i,
  input wire logic idle_to_rx_i,
  input wire logic auto_rx_to_idle_i,
  input wire logic [7:0] channel_spacing_mantissa_o,
  input wire logic [2:0] deviation_mantissa_o,
  input wire logic stay_in_rx_o,
  input wire logic go_idle_o,
  input wire logic cal_request_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence wr_mant; reg_write_i && reg_addr_i == 6'h14; endsequence
  sequence rd_mant; !reg_write_i && reg_addr_i == 6'h14; endsequence
  AST_MANT_WR: assert property (wr_mant |=> channel_spacing_mantissa_o == $past(reg_wdata_i))
    else $error("mantissa not written");
  AST_MANT_RD: assert property (wr_mant ##1 rd_mant |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("mantissa read back wrong");
  AST_MANT_HOLD: assert property (!(reg_write_i && reg_addr_i == 6'h14) |=> $stable(channel_spacing_mantissa_o))
    else $error("mantissa changed");
  AST_OOK_MANT: assert property (on_off_keying_i |-> deviation_mantissa_o == 3'h0)
    else $error("mantissa seen in ook");
  AST_PKT_ONE: assert property (packet_done_i |-> stay_in_rx_o ^ go_idle_o)
    else $error("no single next state");
  AST_PKT_NONE: assert property (!packet_done_i |-> !stay_in_rx_o && !go_idle_o)
    else $error("next state without packet");
  AST_CAL_CAUSE: assert property (cal_request_o |-> idle_to_rx_i || auto_rx_to_idle_i)
    else $error("calibration without transition");
  AST_UNMAPPED: assert property (reg_addr_i == 6'h19 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule // mrc_cfg_bank_properties
bind mrc_cfg_bank mrc_cfg_bank_properties chk_u (.*);
`default_nettype wire

// *** dv/mrc_host_model.sv ***
// host side: byte writes and reads on the register port
// assumes: tasks are entered at a falling clock edge
`timescale 1ns/1ps
`default_nettype none
module mrc_host_model (
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output logic [5:0] addr_o = 6'h00,
  output logic wr_o = 1'b0,
  output logic [7:0] wdata_o = 8'h00
);
  // data inverted once the strobe drops, so stale data never looks valid
  task wr(input logic [5:0] a, input logic [7:0] v);
    addr_o = a;
    wdata_o = v;
    wr_o = 1'b1;
    @(negedge clock_i);
    wr_o = 1'b0;
    wdata_o = ~v;
  endtask
  task rd(input logic [5:0] a, output logic [7:0] v);
    addr_o = a;
    @(negedge clock_i);
    v = rdata_i;
  endtask
endmodule // mrc_host_model
`default_nettype wire

// *** dv/testbench.sv ***
// bench of the configuration bank
// assumes: design, host model and checker compiled before
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_i = 0, resetn_i = 0, on_off_keying = 0, cs = 0, wr, term, stay, gidle, cal;
  logic [4:0] ev = 0;
  logic [3:0] o;
  logic [5:0] addr;
  logic [7:0] d, wdata, rdata, spm;
  logic [2:0] dmant, dexp;
  logic [1:0] spe;
  logic [3:0] n, m;
  int failures = 0, n_compared = 0, cyc = 0, i;
  logic [7:0] rv [6] = '{8'h02, 8'hf8, 8'h47, 8'h07, 8'h30, 8'h00};
  logic [7:0] fv [6] = '{8'h83, 8'hff, 8'h77, 8'h1f, 8'h3f, 8'h30};
  logic [7:0] ce [4] = '{8'h00, 8'h40, 8'h04, 8'h01};
  mrc_host_model host_u (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .wdata_o(wdata));
  mrc_cfg_bank dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_write_i(wr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .on_off_keying_i(on_off_keying), .symbol_tick_i(ev[0]),
    .carrier_sense_i(cs), .rx_start_i(ev[4]), .packet_done_i(ev[3]), .idle_to_rx_i(ev[2]),
    .auto_rx_to_idle_i(ev[1]), .channel_spacing_exponent_o(spe), .channel_spacing_mantissa_o(spm),
    .deviation_exponent_o(dexp), .deviation_mantissa_o(dmant), .rx_terminate_o(term),
    .stay_in_rx_o(stay), .go_idle_o(gidle), .cal_request_o(cal));
  task chk(input logic [7:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, s, e);
    end
  endtask
  // outputs are combinational, so they are caught inside the pulse
  task pulse(input logic [4:0] v);
    ev = v;
    #1 o = {stay, gidle, cal, term};
    @(negedge clock_i);
    ev = 5'h00;
    // idle cycle so the next pulse never raises ev in the step it drops
    @(negedge clock_i);
  endtask
  task complete_run;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
    forever #10 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      complete_run;
    end
  end
  initial
  begin
    repeat (4) @(negedge clock_i);
    resetn_i = 1;
    for (i = 0; i < 6; i++)
    begin
      host_u.rd(6'h13 + i[5:0], d);
      chk(d, rv[i]);
    end
    chk(spe, 2'h2);
    chk(spm, 8'hf8);
    chk(dexp, 3'h4);
    chk(dmant, 3'h7);
    on_off_keying = 1;
    #1 chk(dmant, 3'h0);
    @(negedge clock_i) on_off_keying = 0;
    for (i = 0; i < 6; i++)
    begin
      host_u.wr(6'h13 + i[5:0], 8'hff);
      host_u.rd(6'h13 + i[5:0], d);
      chk(d, fv[i]);
    end
    chk(spe, 2'h3);
    chk(spm, 8'hff);
    chk(dexp, 3'h7);
    host_u.wr(6'h19, 8'hff);
    host_u.rd(6'h19, d);
    chk(d, 8'h00);
    $display("register test done");
    host_u.wr(6'h17, 8'h0c);
    pulse(5'h08);
    chk(o[3:2], 2'h2);
    host_u.wr(6'h17, 8'h00);
    pulse(5'h08);
    chk(o[3:2], 2'h1);
    host_u.wr(6'h17, 8'h04);
    pulse(5'h08);
    chk(o[3:2], 2'h1);
    for (i = 0; i < 4; i++)
    begin
      host_u.wr(6'h18, {2'h0, i[1:0], 4'h0});
      n = 4'h0;
      m = 4'h0;
      repeat (4)
      begin
        pulse(5'h04);
        n += o[1];
        pulse(5'h02);
        m += o[1];
      end
      chk({n, m}, ce[i]);
    end
    $display("event test done");
    host_u.wr(6'h16, 8'h00);
    chk(term, 1'b0);
    @(negedge clock_i);
    host_u.wr(6'h16, 8'h10);
    chk(term, 1'b1);
    cs = 1;
    #1 chk(term, 1'b0);
    @(negedge clock_i) cs = 0;
    on_off_keying = 1;
    pulse(5'h10);
    repeat (7) pulse(5'h01);
    chk(term, 1'b0);
    pulse(5'h01);
    chk(term, 1'b1);
    pulse(5'h10);
    cs = 1;
    pulse(5'h01);
    cs = 0;
    repeat (7) pulse(5'h01);
    chk(term, 1'b0);
    $display("termination test done");
    resetn_i = 0;
    @(negedge clock_i) resetn_i = 1;
    host_u.rd(6'h14, d);
    chk(d, 8'hf8);
    host_u.rd(6'h18, d);
    chk(d, 8'h00);
    chk(spe, 2'h2);
    $display("reset test done");
    complete_run;
  end
endmodule // testbench
`default_nettype wire

// *** include/mrc_defs.vh ***
// mrc_defs.vh: register offsets, field codes and reset values of the
// modem / radio control configuration bank.
// assumes: included by bare name from the design files.
`ifndef MRC_DEFS_VH
`define MRC_DEFS_VH

`define MRC_ADDR_SPC_EXP 6'h13
`define MRC_ADDR_SPC_MANT 6'h14
`define MRC_ADDR_DEVIATION 6'h15
`define MRC_ADDR_RX_TERM 6'h16
`define MRC_ADDR_RX_EXIT 6'h17
`define MRC_ADDR_CAL 6'h18

`define MRC_RST_SPC_EXP 2'h2
`define MRC_RST_SPC_TUNE 1'h0
`define MRC_RST_SPC_MANT 8'hf8
`define MRC_RST_DEV_EXP 3'h4
`define MRC_RST_DEV_MANT 3'h7
`define MRC_RST_RECEIVED_SIGNAL_STRENGTH_TERM 1'h0
`define MRC_RST_TERM_TUNE 4'h7
`define MRC_RST_EXIT_TUNE_HI 2'h3
`define MRC_RST_RXOFF 2'h0
`define MRC_RST_EXIT_TUNE_LO 2'h0
`define MRC_RST_AUTOCAL 2'h0
`define MRC_RST_CAL_TUNE 4'h0

`define MRC_RXOFF_IDLE 2'h0
`define MRC_RXOFF_STAY 2'h3

`define MRC_CAL_NEVER 2'h0
`define MRC_CAL_IDLE_TO_RX 2'h1
`define MRC_CAL_RX_TO_IDLE 2'h2
`define MRC_CAL_EVERY_4TH 2'h3

`define MRC_OOK_SYMBOLS 4'h8

`endif
